// >>> rtl/mrsc_pkg.sv
// Shared constants for the register-block command interpreter.
// Assumes one 100 MHz clock and a 32-bit APB register port.
package mrsc_pkg;
    // APB register offsets (byte addresses)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_OUTADDR = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_RIDX = 8'h0c;
    localparam logic [7:0] ADDR_RDATA = 8'h10;
    // Field positions
    localparam int STAT_BUSY = 0;
    localparam int STAT_ERR = 1;
    localparam int STAT_OP_LSB = 8;
    // Reset values; concatenation opcode is not fixed by the command set
    localparam logic [6:0] CTRL_CONCAT_RST = 7'h16;
    localparam logic [15:0] OUTADDR_RST = 16'h0000;
    // Command codes in command word bits 15-9
    localparam logic [6:0] OP_STORE_STACK = 7'h0e;
    localparam logic [6:0] OP_MOVE_SWAP = 7'h10;
    localparam logic [6:0] OP_PUSH = 7'h12;
    localparam logic [6:0] OP_POP = 7'h14;
    // Register file and matrix layout
    localparam int REG_W = 24;
    localparam int REG_N = 256;
    localparam logic [7:0] MATRIX_ADDR_REG = 8'h1b;
    localparam logic [8:0] MAT_ELEMS = 9'h010;
    localparam int FRAC_BITS = 20;
endpackage : mrsc_pkg

// >>> rtl/mrsc_rf_if.sv
// Carrier between the interpreter core and its register file.
// Three combinational read ports, one synchronous write port.
`timescale 1ns/1ps
`default_nettype none
interface mrsc_rf_if;
    logic [7:0] rdAddrA;
    logic [23:0] rdDataA;
    logic [7:0] rdAddrB;
    logic [23:0] rdDataB;
    logic [7:0] dbgAddr;
    logic [23:0] dbgData;
    logic wrEn;
    logic [7:0] wrAddr;
    logic [23:0] wrData;
    modport core (output rdAddrA, rdAddrB, dbgAddr, wrEn, wrAddr, wrData, input rdDataA, rdDataB, dbgData);
    modport rf (input rdAddrA, rdAddrB, dbgAddr, wrEn, wrAddr, wrData, output rdDataA, rdDataB, dbgData);
endinterface : mrsc_rf_if
`default_nettype wire

// >>> rtl/mrsc_regfile.sv
// The 256 x 24-bit register block in flip-flops.
// Assumes the core issues at most one write per cycle.
`timescale 1ns/1ps
`default_nettype none
module mrsc_regfile (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Core side
    mrsc_rf_if.rf rf
);
    logic [mrsc_pkg::REG_W-1:0] mem [mrsc_pkg::REG_N];

    genvar g;
    generate
        for (g = 0; g < mrsc_pkg::REG_N; g++) begin : gReg
            always_ff @(posedge core_clk) begin
                if (!rstn) begin
                    mem[g] <= '0;
                end else if (rf.wrEn && rf.wrAddr == 8'(g)) begin
                    mem[g] <= rf.wrData;
                end
            end
        end
    endgenerate

    assign rf.rdDataA = mem[rf.rdAddrA];
    assign rf.rdDataB = mem[rf.rdAddrB];
    assign rf.dbgData = mem[rf.dbgAddr];
endmodule : mrsc_regfile
`default_nettype wire

// >>> rtl/mrsc_matmac.sv
// Multiply-accumulate for one matrix element, with normalising output.
// Operands are signed fixed point with FRAC fraction bits.
`timescale 1ns/1ps
`default_nettype none
module mrsc_matmac #(
    parameter int W = mrsc_pkg::REG_W,
    parameter int FRAC = mrsc_pkg::FRAC_BITS
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Operands
    input wire logic en,
    input wire logic first,
    input wire logic signed [W-1:0] a,
    input wire logic signed [W-1:0] b,
    // Result
    output logic [W-1:0] result
);
    localparam int AW = 2 * W + 2;
    logic signed [AW-1:0] acc;
    logic signed [AW-1:0] prod;
    logic signed [AW-1:0] shifted;
    localparam logic signed [AW-1:0] MAXV = AW'((1 << (W - 1)) - 1);
    localparam logic signed [AW-1:0] MINV = -AW'(1 << (W - 1));

    // Widen before multiplying so the full product survives
    assign prod = AW'(a) * AW'(b);
    assign shifted = acc >>> FRAC;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            acc <= '0;
        end else if (en) begin
            acc <= first ? prod : acc + prod;
        end
    end

    // Saturate instead of wrapping so overflow stays visible as a clipped value
    always_comb begin
        if (shifted > MAXV) begin
            result = MAXV[W-1:0];
        end else if (shifted < MINV) begin
            result = MINV[W-1:0];
        end else begin
            result = shifted[W-1:0];
        end
    end
endmodule : mrsc_matmac
`default_nettype wire

// >>> rtl/mrsc_core.sv
// Register-block command interpreter: store-stack, move/swap, push, pop,
// matrix concatenation over a 256 x 24-bit register block.
// Assumes the command FIFO and output sink share core_clk; APB slave on core_clk.
`timescale 1ns/1ps
`default_nettype none
module mrsc_core (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Command word input stream
    input wire logic [15:0] inData,
    input wire logic inValid,
    output logic inReady,
    // Stored word output stream
    output logic [15:0] outData,
    output logic [15:0] outAddr,
    output logic outValid,
    input wire logic outReady,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    typedef enum logic [10:0] {
        ST_IDLE   = 11'h001,
        ST_OPND1  = 11'h002,
        ST_OPND2  = 11'h004,
        ST_SPRD   = 11'h008,
        ST_STORE  = 11'h010,
        ST_MOVE   = 11'h020,
        ST_SWAPB  = 11'h040,
        ST_SPWR   = 11'h080,
        ST_MATIN  = 11'h100,
        ST_MATMAC = 11'h200,
        ST_MATWR  = 11'h400
    } mrsc_state_e;

    mrsc_rf_if rfBus();

    mrsc_state_e stateReg, stateNext;
    logic [6:0] opReg;
    logic mode8Reg, mode9Reg, swapReg, spAddReg, pushReg, halfReg, errReg;
    logic [8:0] cntReg, idxReg;
    logic [7:0] spNumReg, srcReg, dstReg, tmReg;
    logic [1:0] kReg;
    logic [3:0] elemReg;
    logic [23:0] holdReg;
    logic [23:0] inMat [16];
    logic [6:0] concatOpReg;
    logic [15:0] outAddrReg;
    logic [7:0] ridxReg;
    logic inReadyReg, outValidReg, preadyReg, pslverrReg;
    logic [15:0] outDataReg;
    logic [31:0] prdataReg;

    logic take, canEmit, lastIdx, apbWr, apbSetup, macEn;
    logic [15:0] w;
    logic [23:0] macResult;
    logic [8:0] cntDecoded;

    // Operand field holds minus the count; zero stands for the full 256
    function automatic logic [8:0] negCount(input logic [7:0] f);
        return (f == 8'h00) ? 9'h100 : 9'(9'h100 - {1'b0, f});
    endfunction

    function automatic logic [3:0] matIdx(input logic tr, input logic [1:0] r, input logic [1:0] c);
        return tr ? {c, r} : {r, c};
    endfunction

    assign w = inData;
    assign take = inValid && inReadyReg;
    assign canEmit = !outValidReg || outReady;
    assign lastIdx = (idxReg == 9'(cntReg - 9'h001));
    assign cntDecoded = negCount(w[7:0]);
    assign apbSetup = psel && !penable;
    assign apbWr = psel && penable && preadyReg && pwrite;
    assign macEn = (stateReg == ST_MATMAC);

    mrsc_regfile uRegfile (
        .core_clk(core_clk),
        .rstn(rstn),
        .rf(rfBus.rf)
    );

    mrsc_matmac #(
        .W(mrsc_pkg::REG_W),
        .FRAC(mrsc_pkg::FRAC_BITS)
    ) uMac (
        .core_clk(core_clk),
        .rstn(rstn),
        .en(macEn),
        .first(kReg == 2'd0),
        .a(inMat[{elemReg[3:2], kReg}]),
        .b(rfBus.rdDataA),
        .result(macResult)
    );

    // Next state
    always_comb begin
        stateNext = stateReg;
        case (stateReg)
            ST_IDLE: begin
                if (take) begin
                    if (w[15:9] == mrsc_pkg::OP_STORE_STACK || w[15:9] == mrsc_pkg::OP_MOVE_SWAP) begin
                        stateNext = ST_OPND1;
                    end else if (w[15:9] == mrsc_pkg::OP_PUSH || w[15:9] == mrsc_pkg::OP_POP) begin
                        stateNext = w[8] ? ST_OPND1 : ST_SPRD;
                    end else if (w[15:10] == concatOpReg[6:1]) begin
                        // Bit 9 is the transpose modifier, so it is not part of the match
                        stateNext = ST_MATIN;
                    end
                end
            end
            ST_OPND1: begin
                if (take) begin
                    stateNext = (opReg == mrsc_pkg::OP_MOVE_SWAP) ? ST_OPND2 : ST_SPRD;
                end
            end
            ST_OPND2: begin
                if (take) begin
                    stateNext = ST_MOVE;
                end
            end
            ST_SPRD: begin
                if (opReg == mrsc_pkg::OP_STORE_STACK) begin
                    stateNext = ST_STORE;
                end else if (opReg == mrsc_pkg::OP_PUSH) begin
                    stateNext = ST_MOVE;
                end else begin
                    stateNext = ST_SPWR;
                end
            end
            ST_STORE: begin
                if (canEmit && lastIdx && (!mode8Reg || halfReg)) begin
                    stateNext = ST_IDLE;
                end
            end
            ST_MOVE: begin
                if (swapReg) begin
                    stateNext = ST_SWAPB;
                end else if (lastIdx) begin
                    stateNext = pushReg ? ST_SPWR : ST_IDLE;
                end
            end
            ST_SWAPB: begin
                stateNext = lastIdx ? ST_IDLE : ST_MOVE;
            end
            ST_SPWR: begin
                stateNext = ST_IDLE;
            end
            ST_MATIN: begin
                if (take && idxReg == 9'(mrsc_pkg::MAT_ELEMS - 9'h001)) begin
                    stateNext = ST_MATMAC;
                end
            end
            ST_MATMAC: begin
                if (kReg == 2'd3) begin
                    stateNext = ST_MATWR;
                end
            end
            ST_MATWR: begin
                if (elemReg != 4'hf) begin
                    stateNext = ST_MATMAC;
                end else begin
                    stateNext = mode8Reg ? ST_SPWR : ST_MOVE;
                end
            end
            default: begin
                stateNext = ST_IDLE;
            end
        endcase
    end

    // Register file addressing and writes
    always_comb begin
        rfBus.rdAddrA = spNumReg;
        rfBus.rdAddrB = mrsc_pkg::MATRIX_ADDR_REG;
        rfBus.dbgAddr = ridxReg;
        rfBus.wrEn = 1'b0;
        rfBus.wrAddr = dstReg;
        rfBus.wrData = rfBus.rdDataA;
        case (stateReg)
            ST_STORE: begin
                rfBus.rdAddrA = 8'(srcReg + idxReg[7:0]);
            end
            ST_MOVE: begin
                rfBus.rdAddrA = 8'(srcReg + idxReg[7:0]);
                rfBus.rdAddrB = 8'(dstReg + idxReg[7:0]);
                rfBus.wrEn = 1'b1;
                rfBus.wrAddr = 8'(dstReg + idxReg[7:0]);
            end
            ST_SWAPB: begin
                rfBus.wrEn = 1'b1;
                rfBus.wrAddr = 8'(srcReg + idxReg[7:0]);
                rfBus.wrData = holdReg;
            end
            ST_SPWR: begin
                rfBus.wrEn = 1'b1;
                rfBus.wrAddr = spNumReg;
                rfBus.wrData = spAddReg ? 24'(rfBus.rdDataA + {15'h0000, cntReg})
                                        : 24'(rfBus.rdDataA - {15'h0000, cntReg});
            end
            ST_MATMAC: begin
                rfBus.rdAddrA = 8'(tmReg + {4'h0, matIdx(mode9Reg, kReg, elemReg[1:0])});
            end
            ST_MATWR: begin
                rfBus.wrEn = 1'b1;
                rfBus.wrAddr = 8'(tmReg + 8'h10 + {4'h0, matIdx(mode9Reg, elemReg[3:2], elemReg[1:0])});
                rfBus.wrData = macResult;
            end
            default: begin
            end
        endcase
    end

    // Sequencer
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            stateReg <= ST_IDLE;
        end else begin
            stateReg <= stateNext;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            inReadyReg <= 1'b0;
        end else begin
            inReadyReg <= (stateNext == ST_IDLE) || (stateNext == ST_OPND1) ||
                          (stateNext == ST_OPND2) || (stateNext == ST_MATIN);
        end
    end

    // Command decode and operand capture
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            opReg <= '0;
            mode8Reg <= 1'b0;
            mode9Reg <= 1'b0;
            swapReg <= 1'b0;
            spAddReg <= 1'b0;
            pushReg <= 1'b0;
            cntReg <= '0;
            spNumReg <= '0;
            srcReg <= '0;
            dstReg <= '0;
            tmReg <= '0;
        end else begin
            case (stateReg)
                ST_IDLE: begin
                    if (take) begin
                        opReg <= w[15:9];
                        mode8Reg <= w[8];
                        mode9Reg <= w[9];
                        cntReg <= cntDecoded;
                        swapReg <= (w[15:9] == mrsc_pkg::OP_MOVE_SWAP) && w[8];
                        pushReg <= (w[15:9] == mrsc_pkg::OP_PUSH);
                        spAddReg <= (w[15:9] == mrsc_pkg::OP_PUSH);
                        spNumReg <= mrsc_pkg::MATRIX_ADDR_REG;
                        tmReg <= rfBus.rdDataB[7:0];
                    end
                end
                ST_OPND1: begin
                    if (take) begin
                        spNumReg <= w[7:0];
                        srcReg <= w[7:0];
                    end
                end
                ST_OPND2: begin
                    if (take) begin
                        dstReg <= w[7:0];
                    end
                end
                ST_SPRD: begin
                    // Region is the n words ending at the stack top
                    srcReg <= 8'(rfBus.rdDataA[7:0] - cntReg[7:0] + 8'h01);
                    dstReg <= 8'(rfBus.rdDataA[7:0] + 8'h01);
                end
                ST_MOVE: begin
                    if (swapReg) begin
                        holdReg <= rfBus.rdDataB;
                    end
                end
                ST_MATWR: begin
                    if (elemReg == 4'hf) begin
                        // Mode 0 copies scratch back; mode 1 bumps the pointer by 16
                        srcReg <= 8'(tmReg + 8'h10);
                        dstReg <= tmReg;
                        cntReg <= mrsc_pkg::MAT_ELEMS;
                        swapReg <= 1'b0;
                        pushReg <= 1'b0;
                        spAddReg <= 1'b1;
                        spNumReg <= mrsc_pkg::MATRIX_ADDR_REG;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Element counters
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            idxReg <= '0;
            halfReg <= 1'b0;
            kReg <= '0;
            elemReg <= '0;
        end else begin
            case (stateReg)
                ST_STORE: begin
                    if (canEmit) begin
                        halfReg <= mode8Reg && !halfReg;
                        if (!mode8Reg || halfReg) begin
                            idxReg <= 9'(idxReg + 9'h001);
                        end
                    end
                end
                ST_MOVE: begin
                    if (!swapReg) begin
                        idxReg <= lastIdx ? 9'h000 : 9'(idxReg + 9'h001);
                    end
                end
                ST_SWAPB: begin
                    idxReg <= 9'(idxReg + 9'h001);
                end
                ST_MATIN: begin
                    if (take) begin
                        idxReg <= 9'(idxReg + 9'h001);
                    end
                end
                ST_MATMAC: begin
                    kReg <= 2'(kReg + 2'd1);
                end
                ST_MATWR: begin
                    elemReg <= 4'(elemReg + 4'h1);
                    // Copy-back move must start from the first element
                    if (elemReg == 4'hf) begin
                        idxReg <= '0;
                    end
                end
                default: begin
                    idxReg <= '0;
                    halfReg <= 1'b0;
                    kReg <= '0;
                    elemReg <= '0;
                end
            endcase
        end
    end

    // Input matrix holding, words widened into bits 21-6
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            for (int i = 0; i < 16; i++) begin
                inMat[i] <= '0;
            end
        end else if (stateReg == ST_MATIN && take) begin
            inMat[idxReg[3:0]] <= {w[15], w[15], w, 6'h00};
        end
    end

    // Output stream
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            outValidReg <= 1'b0;
            outDataReg <= '0;
        end else if (stateReg == ST_STORE && canEmit) begin
            outValidReg <= 1'b1;
            if (mode8Reg && !halfReg) begin
                outDataReg <= {rfBus.rdDataA[5:0], 8'h00, rfBus.rdDataA[23:22]};
            end else begin
                outDataReg <= rfBus.rdDataA[21:6];
            end
        end else if (outReady) begin
            outValidReg <= 1'b0;
        end
    end

    // Active output address: software load wins over the advance
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            outAddrReg <= mrsc_pkg::OUTADDR_RST;
        end else if (apbWr && paddr == mrsc_pkg::ADDR_OUTADDR) begin
            outAddrReg <= pwdata[15:0];
        end else if (outValidReg && outReady) begin
            outAddrReg <= 16'(outAddrReg + 16'h0001);
        end
    end

    // Software registers
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            concatOpReg <= mrsc_pkg::CTRL_CONCAT_RST;
            ridxReg <= '0;
            errReg <= 1'b0;
        end else begin
            if (apbWr && paddr == mrsc_pkg::ADDR_CTRL) begin
                concatOpReg <= pwdata[6:0];
            end
            if (apbWr && paddr == mrsc_pkg::ADDR_RIDX) begin
                ridxReg <= pwdata[7:0];
            end
            // An unknown opcode in the same cycle as the clear keeps the flag
            if (stateReg == ST_IDLE && take && stateNext == ST_IDLE) begin
                errReg <= 1'b1;
            end else if (apbWr && paddr == mrsc_pkg::ADDR_STATUS && pwdata[mrsc_pkg::STAT_ERR]) begin
                errReg <= 1'b0;
            end
        end
    end

    // APB answer: ready in the first access cycle
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            preadyReg <= 1'b0;
            pslverrReg <= 1'b0;
            prdataReg <= '0;
        end else begin
            preadyReg <= apbSetup;
            pslverrReg <= apbSetup && !(paddr == mrsc_pkg::ADDR_CTRL || paddr == mrsc_pkg::ADDR_OUTADDR ||
                          paddr == mrsc_pkg::ADDR_STATUS || paddr == mrsc_pkg::ADDR_RIDX ||
                          paddr == mrsc_pkg::ADDR_RDATA);
            prdataReg <= '0;
            if (apbSetup && !pwrite) begin
                case (paddr)
                    mrsc_pkg::ADDR_CTRL: prdataReg <= {25'h0000000, concatOpReg};
                    mrsc_pkg::ADDR_OUTADDR: prdataReg <= {16'h0000, outAddrReg};
                    mrsc_pkg::ADDR_STATUS: begin
                        prdataReg[mrsc_pkg::STAT_BUSY] <= (stateReg != ST_IDLE);
                        prdataReg[mrsc_pkg::STAT_ERR] <= errReg;
                        prdataReg[mrsc_pkg::STAT_OP_LSB +: 7] <= opReg;
                    end
                    mrsc_pkg::ADDR_RIDX: prdataReg <= {24'h000000, ridxReg};
                    mrsc_pkg::ADDR_RDATA: prdataReg <= {8'h00, rfBus.dbgData};
                    default: prdataReg <= '0;
                endcase
            end
        end
    end

    assign inReady = inReadyReg;
    assign outValid = outValidReg;
    assign outData = outDataReg;
    assign outAddr = outAddrReg;
    assign prdata = prdataReg;
    assign pready = preadyReg;
    assign pslverr = pslverrReg;
endmodule : mrsc_core
`default_nettype wire

// >>> test/mrsc_core_props.sv
// Port-level checker for the command interpreter.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module mrsc_core_props (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Streams
    input wire logic inReady,
    input wire logic [15:0] outData,
    input wire logic [15:0] outAddr,
    input wire logic outValid,
    input wire logic outReady,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_out_hold: assert property (outValid && !outReady |=> outValid && $stable(outData) && $stable(outAddr))
        else $error("output word changed before taken");
    a_addr_step: assert property (outValid && outReady |=> outAddr == $past(outAddr) + 16'h0001)
        else $error("output address did not step");
    a_quiet_out: assert property ($rose(outValid) |-> !$past(inReady))
        else $error("input taken while storing");
    a_fetch_back: assert property (!inReady |-> ##[0:600] inReady)
        else $error("next command never fetched");
    a_zero_wait: assert property (psel && !penable |=> pready)
        else $error("apb answer late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_reset_idle: assert property (disable iff (1'b0) !rstn |=> !inReady && !outValid && !pready)
        else $error("outputs active in reset");
endmodule : mrsc_core_props
bind mrsc_core mrsc_core_props mrsc_core_props_i (.core_clk(core_clk), .rstn(rstn), .inReady(inReady),
    .outData(outData), .outAddr(outAddr), .outValid(outValid), .outReady(outReady), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// >>> test/mrsc_cmd_src.sv
// Command word source standing in for the input FIFO.
// Holds each word until taken; a released line shows the inverse.
`timescale 1ns/1ps
`default_nettype none
module mrsc_cmd_src (
    // Clock
    input wire logic core_clk,
    // Stream
    input wire logic inReady,
    output logic inValid,
    output logic [15:0] inData
);
    initial begin
        inValid = 1'b0;
        inData = 16'h0000;
    end
    task send(input logic [15:0] w);
        @(posedge core_clk);
        inValid <= 1'b1;
        inData <= w;
        do @(posedge core_clk); while (inReady !== 1'b1);
        inValid <= 1'b0;
        inData <= ~w;
    endtask : send
endmodule : mrsc_cmd_src
`default_nettype wire

// >>> test/map_register_stack_commands_tb.sv
// Self-checking bench for the register-block command interpreter.
// Registers start cleared; pop builds the first nonzero value.
`timescale 1ns/1ps
`default_nettype none
module map_register_stack_commands_tb;
    logic core_clk = 1'b0;
    logic rstn, outReady, psel, penable, pwrite;
    logic [15:0] inData, outData, outAddr;
    logic inValid, inReady, outValid, pready, pslverr, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] cyc = 2'h0;
    logic [31:0] oq[$];
    int errCount = 0;
    int checked = 0;
    always #5 core_clk = ~core_clk;
    // Sink stalls one cycle in four
    always @(posedge core_clk) begin
        cyc <= cyc + 2'h1;
        outReady <= cyc != 2'h0;
        if (outValid === 1'b1 && outReady === 1'b1) oq.push_back({outAddr, outData});
    end
    mrsc_cmd_src mrsc_cmd_src_i (.core_clk(core_clk), .inReady(inReady), .inValid(inValid), .inData(inData));
    mrsc_core mrsc_core_i (.core_clk(core_clk), .rstn(rstn), .inData(inData), .inValid(inValid),
        .inReady(inReady), .outData(outData), .outAddr(outAddr), .outValid(outValid), .outReady(outReady),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errCount++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rreg(input logic [7:0] i, input logic [23:0] e);
        apb(1'b1, mrsc_pkg::ADDR_RIDX, {24'h0, i});
        apb(1'b0, mrsc_pkg::ADDR_RDATA, 32'h0);
        chk(rd, {8'h00, e});
    endtask : rreg
    task idle;
        repeat (4) @(posedge core_clk);
        for (int k = 0; k < 50; k++) begin
            apb(1'b0, mrsc_pkg::ADDR_STATUS, 32'h0);
            if (rd[mrsc_pkg::STAT_BUSY] === 1'b0) break;
        end
    endtask : idle
    task och(input logic [31:0] e);
        chk(oq.size() > 0 ? oq.pop_front() : 32'hdeaddead, e);
    endtask : och
    task t_apb;
        apb(1'b0, 8'h20, 32'h0);
        chk({er, rd[30:0]}, 32'h80000000);
        apb(1'b0, mrsc_pkg::ADDR_CTRL, 32'h0);
        chk(rd, {25'h0, mrsc_pkg::CTRL_CONCAT_RST});
        apb(1'b1, mrsc_pkg::ADDR_OUTADDR, 32'h0100);
        $display("apb done");
    endtask : t_apb
    task t_pop;
        mrsc_cmd_src_i.send(16'h281b);
        idle;
        rreg(8'h1b, 24'hffff1b);
        $display("pop done");
    endtask : t_pop
    task t_store;
        mrsc_cmd_src_i.send(16'h1dff);
        mrsc_cmd_src_i.send(16'h001b);
        idle;
        och(32'h01006c03);
        och(32'h0101fffc);
        mrsc_cmd_src_i.send(16'h1cff);
        mrsc_cmd_src_i.send(16'h001b);
        idle;
        och(32'h0102fffc);
        chk(32'(oq.size()), 32'h0);
        rreg(8'h1b, 24'hffff1b);
        $display("store done");
    endtask : t_store
    task t_reg_move_swap_cmd;
        mrsc_cmd_src_i.send(16'h20ff);
        mrsc_cmd_src_i.send(16'h001b);
        mrsc_cmd_src_i.send(16'h0005);
        idle;
        rreg(8'h05, 24'hffff1b);
        mrsc_cmd_src_i.send(16'h21ff);
        mrsc_cmd_src_i.send(16'h0005);
        mrsc_cmd_src_i.send(16'h0006);
        idle;
        rreg(8'h05, 24'h000000);
        rreg(8'h06, 24'hffff1b);
        $display("reg_move_swap_cmd done");
    endtask : t_reg_move_swap_cmd
    task t_push;
        mrsc_cmd_src_i.send(16'h25ff);
        mrsc_cmd_src_i.send(16'h001b);
        idle;
        rreg(8'h1c, 24'hffff1b);
        rreg(8'h1b, 24'hffff1c);
        mrsc_cmd_src_i.send(16'hfe00);
        idle;
        chk({31'h0, rd[mrsc_pkg::STAT_ERR]}, 32'h1);
        $display("push done");
    endtask : t_push
    // One unit element at position at of the 16 input words
    task concat(input logic [15:0] c, input int at);
        mrsc_cmd_src_i.send(c);
        for (int k = 0; k < 16; k++) mrsc_cmd_src_i.send(k == at ? 16'h4000 : 16'h0000);
        idle;
    endtask : concat
    task t_concat;
        concat(16'h2d00, 4);
        rreg(8'h30, 24'hffff1b);
        rreg(8'h2c, 24'h000000);
        rreg(8'h1b, 24'hffff2c);
        concat(16'h2e00, 4);
        rreg(8'h31, 24'hffff1b);
        rreg(8'h30, 24'h000000);
        rreg(8'h1b, 24'hffff2c);
        $display("concat done");
    endtask : t_concat
    task final_report;
        $display("checks %0d mismatches %0d", checked, errCount);
        if (errCount == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : final_report
    initial begin
        #300000;
        errCount++;
        final_report;
    end
    initial begin
        rstn <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h0;
        repeat (5) @(posedge core_clk);
        rstn <= 1'b1;
        t_apb;
        t_pop;
        t_store;
        t_reg_move_swap_cmd;
        t_push;
        t_concat;
        final_report;
    end
endmodule : map_register_stack_commands_tb
`default_nettype wire
